// ### common/bad_pkg.sv
// Constants and types for the bus area decode and parity block
package bad_pkg;
    localparam logic [7:0] OFF_PARITY = 8'h00;
    localparam logic [7:0] OFF_REF_CTRL = 8'h04;
    localparam logic [7:0] OFF_REF_TCS = 8'h08;
    localparam logic [7:0] OFF_REF_CNT = 8'h0C;
    localparam logic [7:0] OFF_REF_CONST = 8'h10;
    localparam logic [7:0] OFF_BUS_CTRL = 8'h14;
    localparam logic [7:0] PW_REF_CTRL = 8'h5A;
    localparam logic [7:0] PW_REF_TCS = 8'hA5;
    localparam logic [7:0] PW_REF_CNT = 8'h69;
    localparam logic [7:0] PW_REF_CONST = 8'h96;
    localparam int PEF_BIT = 15;
    localparam int FORCE_BIT = 14;
    localparam int POL_BIT = 13;
    localparam int SPACE_HI = 12;
    localparam int SPACE_LO = 11;
    localparam logic [15:0] PARITY_RST = 16'h0000;
    localparam int DRAM_SPACE_ENABLE_BIT = 0;
    localparam int IOE_BIT = 1;
    localparam logic [7:0] BUS_CTRL_RST = 8'h00;
    localparam logic [7:0] REF_RST = 8'h00;
    localparam logic [7:0] REF_CONST_RST = 8'hFF;
    localparam int A_WIDTH = 27;
    localparam int A_AREA_HI = 26;
    localparam int A_AREA_LO = 24;
    localparam int A_PERIPH_W = 8;
    localparam int A_AREA6_W = 14;
    localparam logic [2:0] BOOT_EXT8 = 3'h0;
    localparam logic [2:0] BOOT_EXT16 = 3'h1;
    localparam logic [2:0] BOOT_ROM32 = 3'h2;
    localparam logic [1:0] PSP_DRAM = 2'h1;
    localparam logic [1:0] PSP_DRAM_A2 = 2'h2;
    localparam logic [2:0] AREA_0 = 3'h0;
    localparam logic [2:0] AREA_1 = 3'h1;
    localparam logic [2:0] AREA_2 = 3'h2;
    localparam logic [2:0] AREA_5 = 3'h5;
    localparam logic [2:0] AREA_6 = 3'h6;
    localparam logic [2:0] AREA_7 = 3'h7;
    localparam int CLK_PERIOD_NS = 20;
    localparam int BEAT_TIME_NS = 60;
    localparam logic [1:0] BEAT_CYC = 2'((BEAT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [1:0] {BW_8 = 2'h0, BW_16 = 2'h1, BW_32 = 2'h2} bad_width_e;
    typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2} bad_size_e;
    typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_BEAT = 2'h1, ST_FINISH = 2'h3} bad_state_e;
endpackage : bad_pkg

// ### common/bad_bus_if.sv
// Carrier between the top, the area decoder and the parity unit
`timescale 1ns/10ps
interface bad_bus_if;
    import bad_pkg::*;
    logic [27:0] addr;
    logic [2:0] boot_mode, area;
    bad_width_e width;
    logic dram_en, mux_io_enable, external, dram_space, mux_io, polarity, force_high, par_en, par_bad;
    logic [7:0] cs_n;
    logic [15:0] gen_data, chk_data;
    logic [1:0] lanes, par_pin_in, par_out;

    modport dec (input addr, boot_mode, dram_en, mux_io_enable,
                 output area, width, external, cs_n, dram_space, mux_io);
    modport par (input gen_data, chk_data, lanes, polarity, force_high, par_en, par_pin_in,
                 output par_out, par_bad);
endinterface : bad_bus_if

// ### rtl/bad_area_dec.sv
// Area, width and chip select decode of a transfer address
`timescale 1ns/10ps
module bad_area_dec (
    bad_bus_if.dec bif
);
    import bad_pkg::*;
    logic a27;
    assign a27 = bif.addr[A_WIDTH];
    assign bif.area = bif.addr[A_AREA_HI:A_AREA_LO];

    always_comb begin
        bif.width = a27 ? BW_16 : BW_8;
        bif.external = 1'b1;
        bif.dram_space = 1'b0;
        bif.mux_io = 1'b0;
        case (bif.area)
            AREA_0: begin
                if (bif.boot_mode == BOOT_ROM32) begin
                    bif.width = BW_32;
                    bif.external = 1'b0;
                end else if (bif.boot_mode == BOOT_EXT16) begin
                    bif.width = BW_16;
                end else begin
                    bif.width = BW_8;
                end
            end
            AREA_1: bif.dram_space = bif.dram_en;
            AREA_5: begin
                if (!a27) begin
                    bif.external = 1'b0;
                    bif.width = bif.addr[A_PERIPH_W] ? BW_16 : BW_8;
                end
            end
            AREA_6: begin
                if (!a27) begin
                    bif.width = bif.addr[A_AREA6_W] ? BW_16 : BW_8;
                    bif.mux_io = bif.mux_io_enable;
                end
            end
            AREA_7: begin
                if (a27) begin
                    bif.width = BW_32;
                    bif.external = 1'b0;
                end
            end
            default: bif.external = 1'b1;
        endcase
    end

    always_comb begin
        bif.cs_n = 8'hFF;
        if (bif.external && !bif.dram_space && !bif.mux_io) begin
            bif.cs_n[bif.area] = 1'b0;
        end
    end
endmodule : bad_area_dec

// ### rtl/bad_parity.sv
// Per-lane parity generation and checking
`timescale 1ns/10ps
module bad_parity (
    bad_bus_if.par bif
);
    import bad_pkg::*;
    logic [1:0] lane_bad;

    for (genvar g = 0; g < 2; g++) begin : g_lane
        logic gen_bit;
        assign gen_bit = (^bif.gen_data[8*g+7:8*g]) ^ bif.polarity;
        assign bif.par_out[g] = bif.force_high | gen_bit;
        assign lane_bad[g] = bif.par_en & bif.lanes[g] &
            ((^bif.chk_data[8*g+7:8*g]) ^ bif.par_pin_in[g] ^ bif.polarity);
    end

    assign bif.par_bad = |lane_bad;
endmodule : bad_parity

// ### rtl/bad_top.sv
// Bus area decode, transfer splitting, parity and protected refresh registers
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
// Notes on behaviour
// - Parity control cleared only by power-on reset.
// - Bad parity sets error flag; read as one, then write zero clears.
// - Force bit drives the parity pin of each written lane high on output.
// - Polarity zero even, one odd, both directions.
// - Space field: none, DRAM, DRAM plus area 2, reserved.
// - Low eleven parity control bits read zero.
// - Refresh registers take only word writes.
// - Password 5A loads refresh control; A5 timer control/status.
// - Password 69 loads refresh counter; 96 refresh constant.
// - Wrong password leaves refresh register unchanged.
// - Refresh registers read by byte or word; upper byte zero.
// - Top four address bits ignored, never driven.
// - Bit 27 selects 8 or 16 bit bus by default.
// - Bits 26 to 24 pick one of eight areas and select.
// - Area 0 width and type follow boot mode pins.
// - Area 5 low half peripherals, width by bit 8; else 16-bit.
// - Area 6 low half width by bit 14; else 16-bit.
// - Area 7 is 32-bit on-chip RAM when bit 27 set, else 8-bit.
// - 8-bit bus on low lines; 16-bit byte on its lane.
// - Wide transfers split into two or four accesses.
// - DRAM enable makes area 1 DRAM space.
// - Mux I/O enable makes lower area 6 multiplexed I/O.
// - Area select low only for external accesses.
module bad_top (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclk_en,
    input wire logic manual_reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // CPU transfer port
    input wire logic acc_req,
    input wire logic acc_write,
    input wire bad_pkg::bad_size_e acc_size,
    input wire logic [31:0] acc_addr,
    input wire logic [31:0] acc_wdata,
    output logic acc_busy,
    output logic acc_done,
    output logic [31:0] acc_rdata,
    output logic onchip_req,
    output logic [2:0] onchip_area,
    // External bus pins
    input wire logic [2:0] boot_mode_pins,
    output logic [27:0] ext_addr,
    output logic [7:0] area_selects_n,
    output logic dram_access,
    output logic mux_io_access,
    output logic ext_write,
    input wire logic [15:0] muxed_bus_lines_in,
    output logic [15:0] muxed_bus_lines_out,
    output logic [15:0] muxed_bus_lines_oe,
    input wire logic parity_pin_upper_in,
    output logic parity_pin_upper_out,
    output logic parity_pin_upper_oe,
    input wire logic parity_pin_lower_in,
    output logic parity_pin_lower_out,
    output logic parity_pin_lower_oe
);
    import bad_pkg::*;
    bad_bus_if bif ();
    bad_area_dec u_dec (.bif(bif));
    bad_parity u_par (.bif(bif));

    // Pin synchronisers
    logic [20:0] sync1_reg, sync2_reg;
    logic [15:0] bus_in;
    logic [2:0] boot_mode_s;
    logic [1:0] par_in;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else if (pclk_en) begin
            sync1_reg <= {parity_pin_upper_in, parity_pin_lower_in, boot_mode_pins, muxed_bus_lines_in};
            sync2_reg <= sync1_reg;
        end
    end

    assign bus_in = sync2_reg[15:0];
    assign boot_mode_s = sync2_reg[18:16];
    assign par_in = sync2_reg[20:19];

    // Registers
    logic pef_reg, pef_armed_reg, force_high, polarity;
    logic [3:0] par_ctl_reg;
    logic [7:0] ref_ctrl_reg, ref_tcs_reg, ref_cnt_reg, ref_const_reg, bus_ctrl_reg;
    logic [31:0] prdata_reg;
    logic [1:0] psp;
    assign force_high = par_ctl_reg[FORCE_BIT - SPACE_LO];
    assign polarity = par_ctl_reg[POL_BIT - SPACE_LO];
    assign psp = par_ctl_reg[SPACE_HI - SPACE_LO:0];

    // APB decode
    function automatic logic reg_mapped(input logic [7:0] a);
        reg_mapped = (a == OFF_PARITY) || (a == OFF_REF_CTRL) || (a == OFF_REF_TCS) ||
                     (a == OFF_REF_CNT) || (a == OFF_REF_CONST) || (a == OFF_BUS_CTRL);
    endfunction : reg_mapped
    logic apb_setup, wr_fire, rd_fire, word_wr, pef_set, pef_clear;
    logic [31:0] rd_val;
    assign apb_setup = psel & ~penable;
    assign wr_fire = psel & penable & pwrite;
    assign rd_fire = psel & penable & ~pwrite;
    assign word_wr = pstrb[1] & pstrb[0];
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~reg_mapped(paddr);
    assign prdata = prdata_reg;

    always_comb begin
        case (paddr)
            OFF_PARITY: rd_val = {16'h0000, pef_reg, par_ctl_reg, 11'h000};
            OFF_REF_CTRL: rd_val = 32'(ref_ctrl_reg);
            OFF_REF_TCS: rd_val = 32'(ref_tcs_reg);
            OFF_REF_CNT: rd_val = 32'(ref_cnt_reg);
            OFF_REF_CONST: rd_val = 32'(ref_const_reg);
            OFF_BUS_CTRL: rd_val = 32'(bus_ctrl_reg);
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // Read data captured in the setup phase, zero-wait access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (pclk_en && apb_setup) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : rd_val;
        end
    end

    // Parity control fields; presetn is the power-on reset only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            par_ctl_reg <= PARITY_RST[FORCE_BIT:SPACE_LO];
        end else if (pclk_en && wr_fire && paddr == OFF_PARITY && pstrb[1]) begin
            par_ctl_reg <= pwdata[FORCE_BIT:SPACE_LO];
        end
    end

    // Parity error flag with read-then-write-zero clear
    assign pef_clear = wr_fire && paddr == OFF_PARITY && pstrb[1] && !pwdata[PEF_BIT] && pef_armed_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pef_reg <= PARITY_RST[PEF_BIT];
            pef_armed_reg <= 1'b0;
        end else if (pclk_en) begin
            if (pef_set) begin
                pef_reg <= 1'b1;
            end else if (pef_clear) begin
                pef_reg <= 1'b0;
            end
            if (rd_fire && paddr == OFF_PARITY && pef_reg) begin
                pef_armed_reg <= 1'b1;
            end else if (wr_fire && paddr == OFF_PARITY) begin
                pef_armed_reg <= 1'b0;
            end
        end
    end

    // Password-protected refresh registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_ctrl_reg <= REF_RST;
            ref_tcs_reg <= REF_RST;
            ref_cnt_reg <= REF_RST;
            ref_const_reg <= REF_CONST_RST;
        end else if (pclk_en && wr_fire && word_wr) begin
            if (paddr == OFF_REF_CTRL && pwdata[15:8] == PW_REF_CTRL) begin
                ref_ctrl_reg <= pwdata[7:0];
            end
            if (paddr == OFF_REF_TCS && pwdata[15:8] == PW_REF_TCS) begin
                ref_tcs_reg <= pwdata[7:0];
            end
            if (paddr == OFF_REF_CNT && pwdata[15:8] == PW_REF_CNT) begin
                ref_cnt_reg <= pwdata[7:0];
            end
            if (paddr == OFF_REF_CONST && pwdata[15:8] == PW_REF_CONST) begin
                ref_const_reg <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_ctrl_reg <= BUS_CTRL_RST;
        end else if (pclk_en && wr_fire && paddr == OFF_BUS_CTRL && pstrb[0]) begin
            bus_ctrl_reg <= {6'h00, pwdata[IOE_BIT], pwdata[DRAM_SPACE_ENABLE_BIT]};
        end
    end

    // Transfer sequencer
    function automatic logic [2:0] beat_count(input bad_width_e w, input bad_size_e s);
        beat_count = (s == SZ_LONG) ? ((w == BW_8) ? 3'h4 : (w == BW_16) ? 3'h2 : 3'h1) :
                     (s == SZ_WORD && w == BW_8) ? 3'h2 : 3'h1;
    endfunction : beat_count
    bad_state_e state_reg;
    bad_size_e size_reg;
    bad_width_e width_reg;
    logic we_reg, dram_reg, muxio_reg, par_en_reg, acc_done_reg, onchip_reg;
    logic accept, sample, drive, par_en_new;
    logic [27:0] addr_reg;
    logic [2:0] nb_reg, beat_reg, onchip_area_reg;
    logic [1:0] cyc_reg, lanes;
    logic [7:0] cs_n_reg, in_byte;
    logic [31:0] wshift_reg, rshift_reg, acc_rdata_reg;
    logic [15:0] beat_data;
    assign accept = state_reg == ST_IDLE && acc_req;
    assign sample = state_reg == ST_BEAT && cyc_reg == BEAT_CYC - 2'h1;
    assign drive = state_reg == ST_BEAT && we_reg;
    assign par_en_new = (psp == PSP_DRAM && bif.dram_space) ||
                        (psp == PSP_DRAM_A2 && (bif.dram_space || bif.area == AREA_2));

    // Byte lanes of the current beat
    always_comb begin
        lanes = 2'b01;
        beat_data = {wshift_reg[31:24], wshift_reg[31:24]};
        if (width_reg == BW_16) begin
            if (size_reg == SZ_BYTE) begin
                lanes = addr_reg[0] ? 2'b01 : 2'b10;
            end else begin
                lanes = 2'b11;
                beat_data = wshift_reg[31:16];
            end
        end
    end

    assign in_byte = (lanes == 2'b10) ? bus_in[15:8] : bus_in[7:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            we_reg <= 1'b0;
            size_reg <= SZ_BYTE;
            width_reg <= BW_8;
            addr_reg <= '0;
            nb_reg <= 3'h1;
            beat_reg <= 3'h0;
            cyc_reg <= 2'h0;
            cs_n_reg <= 8'hFF;
            dram_reg <= 1'b0;
            muxio_reg <= 1'b0;
            par_en_reg <= 1'b0;
            wshift_reg <= '0;
            rshift_reg <= '0;
            onchip_reg <= 1'b0;
            onchip_area_reg <= 3'h0;
        end else if (pclk_en) begin
            onchip_reg <= 1'b0;
            if (manual_reset) begin
                state_reg <= ST_IDLE;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        if (accept) begin
                            we_reg <= acc_write;
                            size_reg <= acc_size;
                            width_reg <= bif.width;
                            addr_reg <= acc_addr[27:0];
                            nb_reg <= beat_count(bif.width, acc_size);
                            beat_reg <= 3'h0;
                            cyc_reg <= 2'h0;
                            cs_n_reg <= bif.cs_n;
                            dram_reg <= bif.dram_space;
                            muxio_reg <= bif.mux_io;
                            par_en_reg <= par_en_new;
                            rshift_reg <= '0;
                            case (acc_size)
                                SZ_BYTE: wshift_reg <= {acc_wdata[7:0], 24'h00_0000};
                                SZ_WORD: wshift_reg <= {acc_wdata[15:0], 16'h0000};
                                default: wshift_reg <= acc_wdata;
                            endcase
                            if (bif.external) begin
                                state_reg <= ST_BEAT;
                            end else begin
                                state_reg <= ST_FINISH;
                                onchip_reg <= 1'b1;
                                onchip_area_reg <= bif.area;
                            end
                        end
                    end
                    ST_BEAT: begin
                        cyc_reg <= cyc_reg + 2'h1;
                        if (sample) begin
                            cyc_reg <= 2'h0;
                            if (lanes == 2'b11) begin
                                rshift_reg <= {rshift_reg[15:0], bus_in};
                                wshift_reg <= {wshift_reg[15:0], 16'h0000};
                            end else begin
                                rshift_reg <= {rshift_reg[23:0], in_byte};
                                wshift_reg <= {wshift_reg[23:0], 8'h00};
                            end
                            if (beat_reg == nb_reg - 3'h1) begin
                                state_reg <= ST_FINISH;
                            end else begin
                                beat_reg <= beat_reg + 3'h1;
                                addr_reg <= addr_reg + ((width_reg == BW_16) ? 28'h000_0002 : 28'h000_0001);
                            end
                        end
                    end
                    ST_FINISH: state_reg <= ST_IDLE;
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end

    // Completion and returned data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_done_reg <= 1'b0;
            acc_rdata_reg <= 32'h0000_0000;
        end else if (pclk_en) begin
            acc_done_reg <= state_reg == ST_FINISH && !manual_reset;
            if (state_reg == ST_FINISH) begin
                acc_rdata_reg <= we_reg ? 32'h0000_0000 : rshift_reg;
            end
        end
    end

    // Parity unit and decoder hookup
    assign bif.addr = acc_addr[27:0];
    assign bif.boot_mode = boot_mode_s;
    assign bif.dram_en = bus_ctrl_reg[DRAM_SPACE_ENABLE_BIT];
    assign bif.mux_io_enable = bus_ctrl_reg[IOE_BIT];
    assign bif.gen_data = beat_data;
    assign bif.chk_data = bus_in;
    assign bif.lanes = lanes;
    assign bif.polarity = polarity;
    assign bif.force_high = force_high;
    assign bif.par_en = par_en_reg;
    assign bif.par_pin_in = par_in;
    assign pef_set = sample && !we_reg && bif.par_bad;

    // Outputs
    assign acc_busy = state_reg != ST_IDLE;
    assign acc_done = acc_done_reg;
    assign acc_rdata = acc_rdata_reg;
    assign onchip_req = onchip_reg;
    assign onchip_area = onchip_area_reg;
    assign ext_addr = addr_reg;
    assign area_selects_n = (state_reg == ST_BEAT) ? cs_n_reg : 8'hFF;
    assign dram_access = state_reg == ST_BEAT && dram_reg;
    assign mux_io_access = state_reg == ST_BEAT && muxio_reg;
    assign ext_write = drive;
    assign muxed_bus_lines_out = beat_data;
    assign muxed_bus_lines_oe = {{8{drive & lanes[1]}}, {8{drive & lanes[0]}}};
    assign parity_pin_upper_out = bif.par_out[1];
    assign parity_pin_lower_out = bif.par_out[0];
    assign parity_pin_upper_oe = drive & lanes[1] & (par_en_reg | force_high);
    assign parity_pin_lower_oe = drive & lanes[0] & (par_en_reg | force_high);
endmodule : bad_top

// ### tb/bad_properties.sv
// Port assertions for bad_top
`timescale 1ns/10ps
module bad_properties (
    // Observed top ports
    input wire logic pclk,
    input wire logic presetn,
    input wire logic acc_req,
    input wire logic acc_busy,
    input wire logic acc_done,
    input wire logic onchip_req,
    input wire logic [7:0] area_selects_n,
    input wire logic dram_access,
    input wire logic ext_write,
    input wire logic [15:0] muxed_bus_lines_oe,
    input wire logic parity_pin_upper_oe
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_SEL: assert property ($onehot0(~area_selects_n)) else $error("selects");
    AST_ONCHIP: assert property (onchip_req |-> &area_selects_n) else $error("onchip select");
    AST_DRAM: assert property (dram_access |-> area_selects_n[1]) else $error("dram select");
    AST_DONE: assert property (acc_done |=> !acc_done) else $error("done width");
    AST_IDLE: assert property (acc_done |-> !acc_busy) else $error("busy at done");
    AST_BUSY: assert property ($rose(acc_busy) |-> $past(acc_req)) else $error("busy cause");
    AST_OE: assert property (|muxed_bus_lines_oe |-> ext_write) else $error("read driven");
    AST_POE: assert property (parity_pin_upper_oe |-> ext_write) else $error("parity driven");
endmodule : bad_properties
bind bad_top bad_properties u_props (.pclk, .presetn, .acc_req, .acc_busy, .acc_done, .onchip_req,
    .area_selects_n, .dram_access, .ext_write, .muxed_bus_lines_oe, .parity_pin_upper_oe);

// ### tb/bad_mem_model.sv
// External memory answering beats on the muxed bus
`timescale 1ns/10ps
module bad_mem_model (
    // Beat and fault control
    input wire logic pclk,
    input wire logic [27:0] ext_addr,
    input wire logic act,
    input wire logic odd,
    input wire logic bad,
    // Read answer
    output logic [15:0] data,
    output logic pu,
    output logic pl
);
    logic [17:0] ans;
    logic [17:0] last = 18'h0_0000;
    assign ans[15:0] = {~ext_addr[7:0], ext_addr[7:0]};
    assign ans[17:16] = {^ans[15:8], ^ans[7:0]} ^ {2{odd ^ bad}};
    always_ff @(posedge pclk) if (act) last <= ans;
    // Released lines show the inverse
    assign {pu, pl, data} = act ? ans : ~last;
endmodule : bad_mem_model

// ### tb/bad_top_tb.sv
// Self-checking bench for bad_top
`timescale 1ns/10ps
module bad_top_tb;
    import bad_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, manual_reset = 0, acc_req = 0, acc_write = 0;
    logic odd = 0, bad = 0, on_seen, pu, pl, pready, pslverr, acc_busy, acc_done, onchip_req, dram_access;
    logic mux_io_access, ext_write, up_oe, up_out, lo_out;
    logic [7:0] paddr = 0, sel, area_selects_n;
    logic [31:0] pwdata = 0, acc_addr = 0, acc_wdata = 0, rd, prdata, acc_rdata;
    logic [3:0] pstrb = 0;
    logic [2:0] boot_mode_pins = 0;
    logic [1:0] pins;
    logic [15:0] oe, lines, lines_oe;
    logic [27:0] ext_addr;
    bad_size_e acc_size = SZ_BYTE;
    int n_fail = 0, n_tests = 0;
    bad_top dut (.pclk, .presetn, .pclk_en(1'b1), .manual_reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .acc_req, .acc_write, .acc_size, .acc_addr, .acc_wdata, .acc_busy, .acc_done,
        .acc_rdata, .onchip_req, .onchip_area(), .boot_mode_pins, .ext_addr, .area_selects_n, .dram_access,
        .mux_io_access, .ext_write, .muxed_bus_lines_in(lines), .muxed_bus_lines_out(), .muxed_bus_lines_oe(lines_oe),
        .parity_pin_upper_in(pu), .parity_pin_upper_out(up_out), .parity_pin_upper_oe(up_oe),
        .parity_pin_lower_in(pl), .parity_pin_lower_out(lo_out), .parity_pin_lower_oe());
    bad_mem_model mem (.pclk, .ext_addr, .act(~&area_selects_n | dram_access | mux_io_access), .odd, .bad,
        .data(lines), .pu, .pl);
    initial forever #10 pclk = ~pclk;
    task automatic chk(input logic [31:0] e, input logic [31:0] g, input string nm);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n = 0;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        {psel, penable} <= 2'b00;
        n_fail += (n >= 20);
        if (n >= 20) final_report();
    endtask : apb
    task automatic acc(input logic w, input bad_size_e z, input logic [31:0] a, input logic [31:0] d);
        int n = 0;
        {sel, on_seen, oe} = {8'hFF, 1'b0, 16'h0000};
        @(posedge pclk);
        {acc_req, acc_write, acc_addr, acc_wdata} <= {1'b1, w, a, d};
        acc_size <= z;
        @(posedge pclk);
        acc_req <= 0;
        do begin
            @(negedge pclk);
            n++;
            sel &= area_selects_n;
            on_seen |= onchip_req;
            oe |= lines_oe;
            if (up_oe === 1'b1) pins = {up_out, lo_out};
        end while (acc_done !== 1'b1 && n < 40);
        n_fail += (n >= 40);
        if (n >= 40) final_report();
    endtask : acc
    task automatic t_regs;
        logic [7:0] p[4] = '{PW_REF_CTRL, PW_REF_TCS, PW_REF_CNT, PW_REF_CONST};
        apb(1, OFF_PARITY, 32'h0000_7FFF, 4'h3);
        manual_reset <= 1;
        @(posedge pclk);
        manual_reset <= 0;
        apb(0, OFF_PARITY, 0, 0);
        chk(32'h0000_7800, rd, "parity");
        for (int i = 0; i < 4; i++) begin
            apb(1, 8'(4 + 4 * i), {16'h0000, ~p[i], 8'h30}, 4'h3);
            apb(1, 8'(4 + 4 * i), {16'h0000, p[i], 8'h30}, 4'h1);
            apb(0, 8'(4 + 4 * i), 0, 0);
            chk(i == 3 ? 32'h0000_00FF : 0, rd, "ref_kept");
            apb(1, 8'(4 + 4 * i), {16'h0000, p[i], 8'h30}, 4'h3);
            apb(0, 8'(4 + 4 * i), 0, 0);
            chk(32'h0000_0030, rd, "ref_load");
        end
    endtask : t_regs
    task automatic t_areas;
        for (int j = 0; j < 2; j++)
            for (int k = 0; k < 8; k++) begin
                acc(0, SZ_BYTE, {4'hF, 1'(j), 3'(k), 24'h00_0010}, 0);
                chk(j ? k == 7 : k == 5, on_seen, "onchip");
                chk(8'(on_seen ? 8'hFF : ~(8'h01 << k)), sel, "selects");
            end
        acc(0, SZ_LONG, 32'h0300_0010, 0);
        chk(32'h1011_1213, acc_rdata, "long8");
        acc(0, SZ_LONG, 32'h0B00_0010, 0);
        chk(32'hEF10_ED12, acc_rdata, "long16");
        acc(0, SZ_WORD, 32'h0600_4020, 0);
        chk(32'h0000_DF20, acc_rdata, "a6_16");
        acc(0, SZ_WORD, 32'h0600_0020, 0);
        chk(32'h0000_2021, acc_rdata, "a6_8");
        acc(1, SZ_BYTE, 32'h0B00_0011, 32'h0000_00A5);
        chk(16'h00FF, oe, "lane");
        @(posedge pclk);
        boot_mode_pins <= BOOT_ROM32;
        repeat (3) @(posedge pclk);
        acc(0, SZ_BYTE, 32'h0000_0010, 0);
        chk(1, on_seen, "rom");
        @(posedge pclk);
        boot_mode_pins <= BOOT_EXT16;
        repeat (3) @(posedge pclk);
        acc(0, SZ_BYTE, 32'h0000_0010, 0);
        chk(32'h0000_00EF, acc_rdata, "boot16");
    endtask : t_areas
    task automatic t_parity;
        apb(1, OFF_BUS_CTRL, 32'h0000_0001, 4'h1);
        apb(1, OFF_PARITY, 32'h0000_0800, 4'h3);
        bad <= 1;
        acc(0, SZ_BYTE, 32'h0100_0010, 0);
        apb(0, OFF_PARITY, 0, 0);
        chk(32'h0000_8800, rd, "flag_set");
        apb(1, OFF_PARITY, 32'h0000_0800, 4'h3);
        acc(0, SZ_BYTE, 32'h0200_0010, 0);
        apb(0, OFF_PARITY, 0, 0);
        chk(32'h0000_0800, rd, "flag_clr");
        apb(1, OFF_PARITY, 32'h0000_3000, 4'h3);
        {bad, odd} <= 2'b01;
        acc(0, SZ_BYTE, 32'h0200_0010, 0);
        apb(0, OFF_PARITY, 0, 0);
        chk(32'h0000_3000, rd, "odd_ok");
        bad <= 1;
        acc(0, SZ_BYTE, 32'h0200_0010, 0);
        apb(0, OFF_PARITY, 0, 0);
        chk(32'h0000_B000, rd, "flag_a2");
        apb(1, OFF_PARITY, 32'h0000_4000, 4'h3);
        acc(1, SZ_WORD, 32'h0B00_0010, 0);
        chk(2'b11, pins, "forced");
        apb(1, OFF_PARITY, 32'h0000_1000, 4'h3);
        acc(1, SZ_WORD, 32'h0A00_0010, 32'h0000_0100);
        chk(2'b10, pins, "gen");
    endtask : t_parity
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        apb(0, OFF_PARITY, 0, 0);
        chk(0, rd, "reset");
        t_regs();
        t_areas();
        t_parity();
        final_report();
    end
endmodule : bad_top_tb
